/* common/serial_pin_pkg.sv */
// Constants and types shared by the serial clock and pin routing logic
package serial_pin_pkg;

    // Register map: printed offsets are word indices, byte address is 4x
    localparam logic [7:0] CTRL_INDEX = 8'h13;
    localparam logic [7:0] STATUS_INDEX = 8'h14;
    localparam logic [7:0] CTRL_ADDR = 8'(CTRL_INDEX * 4);
    localparam logic [7:0] STATUS_ADDR = 8'(STATUS_INDEX * 4);

    // Control register fields
    localparam int SEL_BIT = 8;
    localparam int DIS_BIT = 7;
    localparam int CODE_LSB = 5;
    localparam int CODE_W = 2;
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 5;

    // Status register fields
    localparam int ST_CLK_BIT = 0;
    localparam int ST_EXT_BIT = 1;
    localparam int ST_P1_EN_BIT = 2;
    localparam int ST_P2_EN_BIT = 3;
    localparam int ST_IR_BIT = 4;

    // Reset values that do not come from straps
    localparam logic DISABLE_RESET = 1'b0;
    localparam logic [DIV_W-1:0] DIVISOR_RESET = 5'h1B;

    // Synchroniser depth for the external clock pin
    localparam int SYNC_STAGES = 2;

    // Output enables of the eight pins per allocation
    localparam logic [7:0] OE_ALL_FIRST = 8'h2A;
    localparam logic [7:0] OE_SHARED = 8'hAA;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PIN_ALL_FIRST = 2'b00,
        PIN_SPLIT_FOUR = 2'b01,
        PIN_SECOND_IR = 2'b10,
        PIN_SECOND_RAW = 2'b11
    } pin_code_t;

endpackage

/* src/serial_clock_pin_sync.sv */
// Two-stage synchroniser for the external serial clock pin
module serial_clock_pin_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_in,
    output logic sync_out
);
    import serial_pin_pkg::*;

    logic meta_ff;
    logic sync_ff;

    // Only sync_ff reads meta_ff; nothing else may look at it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

    property p_sync_delay;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) && $past(aresetn, 2) |-> sync_ff == $past(pin_in, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("synchronised clock does not lag the pin by two cycles");

endmodule

/* src/serial_clock_divider.sv */
// Loadable down counter dividing the core clock into a serial clock
module serial_clock_divider (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [serial_pin_pkg::DIV_W-1:0] divisor,
    output logic div_clk
);
    import serial_pin_pkg::*;

    logic [DIV_W-1:0] count_ff;
    logic div_clk_ff;
    logic reload;

    // A divisor of zero is treated like one rather than wrapping
    assign reload = (count_ff <= 5'h01);

    // New divisor only takes effect at a reload, so no short pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_ff <= DIVISOR_RESET;
        end else if (reload) begin
            count_ff <= divisor;
        end else begin
            count_ff <= count_ff - 5'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_clk_ff <= 1'b0;
        end else if (reload) begin
            div_clk_ff <= ~div_clk_ff;
        end
    end

    assign div_clk = div_clk_ff;

    property p_toggle_at_one;
        @(posedge aclk) disable iff (!aresetn)
        count_ff == 5'h01 |=> div_clk_ff != $past(div_clk_ff)
            && count_ff == $past(divisor);
    endproperty
    a_toggle_at_one: assert property (p_toggle_at_one)
        else $error("divider did not toggle and reload at one");

    property p_hold_while_counting;
        @(posedge aclk) disable iff (!aresetn)
        count_ff > 5'h01 |=> $stable(div_clk_ff)
            && count_ff == $past(count_ff) - 5'h01;
    endproperty
    a_hold_while_counting: assert property (p_hold_while_counting)
        else $error("divider output moved while counting down");

endmodule

/* src/serial_port_clock_pin_routing.sv */
// Serial port clock source, first-port disable and pin allocation
// How it works
// - With the source select set, the external clock pin clocks both ports.
// - With the source select clear, the internal divider clocks both ports.
// - The first port is disabled while its disable bit is one.
// - Code 00 gives all eight pins to the first port; the second is off.
// - Code 01 gives each port receive, transmit, clear and request to send.
// - Code 10 puts the second port in infrared mode, six pins to the first.
// - Code 11 gives the second port plain receive and transmit pins.
// - The divider toggles the clock and reloads when its count reaches one.
// - Reset takes the select and code bits from straps, divisor 11011.
module serial_port_clock_pin_routing (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic dram_address_strap_high,
    input wire logic dram_address_strap_low,
    input wire logic ext_serial_port_clock,
    input wire logic [7:0] ext_pin_in,
    output logic [7:0] ext_pin_out,
    output logic [7:0] ext_pin_oe,
    output logic serial_port_clock,
    output logic first_port_enable,
    output logic second_port_enable,
    output logic second_port_ir_mode,
    input wire logic first_port_txd,
    input wire logic first_port_rts_n,
    input wire logic first_port_dtr_n,
    output logic first_port_rxd,
    output logic first_port_cts_n,
    output logic first_port_dsr_n,
    output logic first_port_dcd_n,
    output logic first_port_ri_n,
    input wire logic second_port_txd,
    input wire logic second_port_rts_n,
    output logic second_port_rxd,
    output logic second_port_cts_n
);
    import serial_pin_pkg::*;

    function automatic logic addr_hit(input logic [7:0] addr,
                                      input logic [7:0] reg_addr);
        addr_hit = (addr == reg_addr);
    endfunction

    // Control register fields
    logic sel_ff;
    logic disable_ff;
    pin_code_t code_ff;
    logic [DIV_W-1:0] divisor_ff;

    // Bus slave state
    logic aw_held_ff;
    logic w_held_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic do_write;
    logic wr_ctrl;

    // Clocking and routing
    logic ext_clk_sync;
    logic div_clk;
    logic clk_ff;
    logic p1_en_ff;
    logic p2_en_ff;
    logic ir_ff;
    logic [7:0] nxt_pin_out;
    logic [7:0] nxt_pin_oe;
    logic [4:0] nxt_p1_in;
    logic [1:0] nxt_p2_in;
    logic [7:0] pin_out_ff;
    logic [7:0] pin_oe_ff;
    logic [4:0] p1_in_ff;
    logic [1:0] p2_in_ff;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;

    serial_clock_pin_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(ext_serial_port_clock),
        .sync_out(ext_clk_sync)
    );

    serial_clock_divider u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .divisor(divisor_ff),
        .div_clk(div_clk)
    );

    // Write path: address and data are taken in either order
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign do_write = aw_held_ff && w_held_ff;
    assign wr_ctrl = do_write && addr_hit(awaddr_ff, CTRL_ADDR);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            awaddr_ff <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff <= 1'b0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    // Status is read-only: writes to it are accepted and dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (wr_ctrl || addr_hit(awaddr_ff, STATUS_ADDR))
                ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // Straps are sampled every reset cycle, so the released value holds
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_ff <= dram_address_strap_high;
            disable_ff <= DISABLE_RESET;
            code_ff <= pin_code_t'({dram_address_strap_low,
                                    dram_address_strap_low});
            divisor_ff <= DIVISOR_RESET;
        end else if (wr_ctrl) begin
            if (wstrb_ff[0]) begin
                disable_ff <= wdata_ff[DIS_BIT];
                code_ff <= pin_code_t'(wdata_ff[CODE_LSB +: CODE_W]);
                divisor_ff <= wdata_ff[DIV_LSB +: DIV_W];
            end
            if (wstrb_ff[1]) begin
                sel_ff <= wdata_ff[SEL_BIT];
            end
        end
    end

    // Read path
    always_comb begin
        ctrl_word = 32'h00000000;
        ctrl_word[SEL_BIT] = sel_ff;
        ctrl_word[DIS_BIT] = disable_ff;
        ctrl_word[CODE_LSB +: CODE_W] = code_ff;
        ctrl_word[DIV_LSB +: DIV_W] = divisor_ff;
        status_word = 32'h00000000;
        status_word[ST_CLK_BIT] = clk_ff;
        status_word[ST_EXT_BIT] = ext_clk_sync;
        status_word[ST_P1_EN_BIT] = p1_en_ff;
        status_word[ST_P2_EN_BIT] = p2_en_ff;
        status_word[ST_IR_BIT] = ir_ff;
    end

    assign s_axi_arready = !rvalid_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            if (addr_hit(s_axi_araddr, CTRL_ADDR)) begin
                rdata_ff <= ctrl_word;
                rresp_ff <= RESP_OKAY;
            end else if (addr_hit(s_axi_araddr, STATUS_ADDR)) begin
                rdata_ff <= status_word;
                rresp_ff <= RESP_OKAY;
            end else begin
                rdata_ff <= 32'h00000000;
                rresp_ff <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // Clock source: both inputs are already core-clock flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_ff <= 1'b0;
        end else if (sel_ff) begin
            clk_ff <= ext_clk_sync;
        end else begin
            clk_ff <= div_clk;
        end
    end

    assign serial_port_clock = clk_ff;

    // Pin allocation; unconnected core inputs sit at their idle level
    always_comb begin
        nxt_pin_out = 8'h00;
        nxt_pin_oe = OE_SHARED;
        nxt_p1_in = 5'h1F;
        nxt_p2_in = 2'h3;
        nxt_p1_in[0] = ext_pin_in[0];
        nxt_pin_out[1] = first_port_txd;
        nxt_p1_in[1] = ext_pin_in[2];
        nxt_pin_out[3] = first_port_rts_n;
        case (code_ff)
            PIN_ALL_FIRST: begin
                nxt_pin_oe = OE_ALL_FIRST;
                nxt_p1_in[2] = ext_pin_in[4];
                nxt_pin_out[5] = first_port_dtr_n;
                nxt_p1_in[3] = ext_pin_in[6];
                nxt_p1_in[4] = ext_pin_in[7];
            end
            PIN_SPLIT_FOUR: begin
                nxt_p2_in[0] = ext_pin_in[4];
                nxt_pin_out[5] = second_port_txd;
                nxt_p2_in[1] = ext_pin_in[6];
                nxt_pin_out[7] = second_port_rts_n;
            end
            PIN_SECOND_IR, PIN_SECOND_RAW: begin
                nxt_p1_in[2] = ext_pin_in[4];
                nxt_pin_out[5] = first_port_dtr_n;
                nxt_p2_in[0] = ext_pin_in[6];
                nxt_pin_out[7] = second_port_txd;
            end
            default: begin
                nxt_pin_oe = OE_ALL_FIRST;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out_ff <= 8'h00;
            pin_oe_ff <= 8'h00;
            p1_in_ff <= 5'h1F;
            p2_in_ff <= 2'h3;
        end else begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
            p1_in_ff <= nxt_p1_in;
            p2_in_ff <= nxt_p2_in;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p1_en_ff <= 1'b0;
            p2_en_ff <= 1'b0;
            ir_ff <= 1'b0;
        end else begin
            p1_en_ff <= !disable_ff;
            p2_en_ff <= (code_ff != PIN_ALL_FIRST);
            ir_ff <= (code_ff == PIN_SECOND_IR);
        end
    end

    assign ext_pin_out = pin_out_ff;
    assign ext_pin_oe = pin_oe_ff;
    assign first_port_rxd = p1_in_ff[0];
    assign first_port_cts_n = p1_in_ff[1];
    assign first_port_dsr_n = p1_in_ff[2];
    assign first_port_dcd_n = p1_in_ff[3];
    assign first_port_ri_n = p1_in_ff[4];
    assign second_port_rxd = p2_in_ff[0];
    assign second_port_cts_n = p2_in_ff[1];
    assign first_port_enable = p1_en_ff;
    assign second_port_enable = p2_en_ff;
    assign second_port_ir_mode = ir_ff;

    property p_ext_source;
        @(posedge aclk) disable iff (!aresetn)
        sel_ff |=> clk_ff == $past(ext_clk_sync);
    endproperty
    a_ext_source: assert property (p_ext_source)
        else $error("serial clock does not follow external pin");

    property p_div_source;
        @(posedge aclk) disable iff (!aresetn)
        !sel_ff |=> clk_ff == $past(div_clk);
    endproperty
    a_div_source: assert property (p_div_source)
        else $error("serial clock does not follow the divider");

    property p_first_disable;
        @(posedge aclk) disable iff (!aresetn)
        disable_ff ##1 disable_ff |-> !first_port_enable;
    endproperty
    a_first_disable: assert property (p_first_disable)
        else $error("first port enabled while disabled");

    property p_all_first;
        @(posedge aclk) disable iff (!aresetn)
        code_ff == PIN_ALL_FIRST |=> !second_port_enable
            && ext_pin_oe == OE_ALL_FIRST
            && first_port_ri_n == $past(ext_pin_in[7]);
    endproperty
    a_all_first: assert property (p_all_first)
        else $error("code 00 routing wrong");

    property p_split_four;
        @(posedge aclk) disable iff (!aresetn)
        code_ff == PIN_SPLIT_FOUR |=> ext_pin_out[5] == $past(second_port_txd)
            && second_port_cts_n == $past(ext_pin_in[6]);
    endproperty
    a_split_four: assert property (p_split_four)
        else $error("code 01 routing wrong");

    property p_second_ir;
        @(posedge aclk) disable iff (!aresetn)
        code_ff == PIN_SECOND_IR |=> second_port_ir_mode
            && ext_pin_out[7] == $past(second_port_txd)
            && first_port_dsr_n == $past(ext_pin_in[4]);
    endproperty
    a_second_ir: assert property (p_second_ir)
        else $error("code 10 routing wrong");

    property p_second_raw;
        @(posedge aclk) disable iff (!aresetn)
        code_ff == PIN_SECOND_RAW |=> !second_port_ir_mode
            && second_port_rxd == $past(ext_pin_in[6])
            && ext_pin_out[5] == $past(first_port_dtr_n);
    endproperty
    a_second_raw: assert property (p_second_raw)
        else $error("code 11 routing wrong");

    property p_reset_values;
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> divisor_ff == DIVISOR_RESET && !disable_ff
            && sel_ff == $past(dram_address_strap_high)
            && code_ff == {2{$past(dram_address_strap_low)}};
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("control register reset value wrong");

endmodule

/* bench/serial_far_side.sv */
// Far side model: the two serial port cores and the line on the eight pins
module serial_far_side #(
    parameter int EXT_HALF = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_run,
    input wire logic [12:0] pattern,
    input wire logic [7:0] ext_pin_out,
    input wire logic [7:0] ext_pin_oe,
    output logic ext_serial_port_clock,
    output logic [7:0] ext_pin_in,
    output logic first_port_txd,
    output logic first_port_rts_n,
    output logic first_port_dtr_n,
    output logic second_port_txd,
    output logic second_port_rts_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_ff;
    // A pin the block drives reads back its own level, not the line's
    assign ext_pin_in = (ext_pin_oe & ext_pin_out)
        | (~ext_pin_oe & pattern[7:0]);
    assign {second_port_rts_n, second_port_txd, first_port_dtr_n,
            first_port_rts_n, first_port_txd} = pattern[12:8];
    // The pin clock stands low between bursts, as a real oscillator gate would
    always_ff @(posedge aclk) begin
        if (!aresetn || !clk_run) begin
            cnt_ff <= 4'h0;
            ext_serial_port_clock <= 1'b0;
        end else if (cnt_ff == 4'(EXT_HALF - 1)) begin
            cnt_ff <= 4'h0;
            ext_serial_port_clock <= !ext_serial_port_clock;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule

/* bench/serial_port_clock_pin_routing_tb_top.sv */
// Self-checking bench for the serial clock and pin routing block
module serial_port_clock_pin_routing_tb_top import serial_pin_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ext_serial_port_clock, serial_port_clock;
    logic dram_address_strap_high = 1'b0, dram_address_strap_low = 1'b0;
    logic clk_run = 1'b0;
    logic [12:0] pattern = 13'h1FFF;
    logic [7:0] ext_pin_in, ext_pin_out, ext_pin_oe;
    logic first_port_enable, second_port_enable, second_port_ir_mode;
    logic first_port_txd, first_port_rts_n, first_port_dtr_n;
    logic first_port_rxd, first_port_cts_n, first_port_dsr_n;
    logic first_port_dcd_n, first_port_ri_n, second_port_txd;
    logic second_port_rts_n, second_port_rxd, second_port_cts_n;
    logic [15:0] lfsr_state = 16'h29D3;
    int num_errors = 0;
    int n_checks = 0;

    always #50 aclk = ~aclk;

    serial_port_clock_pin_routing dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .dram_address_strap_high,
        .dram_address_strap_low, .ext_serial_port_clock, .ext_pin_in,
        .ext_pin_out, .ext_pin_oe, .serial_port_clock, .first_port_enable,
        .second_port_enable, .second_port_ir_mode, .first_port_txd,
        .first_port_rts_n, .first_port_dtr_n, .first_port_rxd,
        .first_port_cts_n, .first_port_dsr_n, .first_port_dcd_n,
        .first_port_ri_n, .second_port_txd, .second_port_rts_n,
        .second_port_rxd, .second_port_cts_n);

    serial_far_side #(.EXT_HALF(3)) far (.aclk, .aresetn, .clk_run, .pattern,
        .ext_pin_out, .ext_pin_oe, .ext_serial_port_clock, .ext_pin_in,
        .first_port_txd, .first_port_rts_n, .first_port_dtr_n,
        .second_port_txd, .second_port_rts_n);

    function automatic logic [15:0] rnd();
        lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13]
                      ^ lfsr_state[12] ^ lfsr_state[10]};
        return lfsr_state;
    endfunction

    // Pattern bits 12:8 are rts2, txd2, dtr1, rts1, txd1 from the cores
    function automatic logic [7:0] exp_out(input logic [1:0] c,
                                           input logic [12:0] p);
        logic b5;
        logic b7;
        b5 = (c == 2'b01) ? p[11] : p[10];
        b7 = (c == 2'b00) ? 1'b0 : ((c == 2'b01) ? p[12] : p[11]);
        return {b7, 1'b0, b5, 1'b0, p[9], 1'b0, p[8], 1'b0};
    endfunction

    function automatic logic [6:0] exp_core(input logic [1:0] c,
                                            input logic [12:0] p);
        return {p[0], p[2], (c != 2'b01) ? p[4] : 1'b1,
                (c == 2'b00) ? p[6] : 1'b1, (c == 2'b00) ? p[7] : 1'b1,
                (c == 2'b00) ? 1'b1 : ((c == 2'b01) ? p[4] : p[6]),
                (c == 2'b01) ? p[6] : 1'b1};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] r);
        bit aw_ok;
        bit w_ok;
        logic [15:0] p;
        aw_ok = 0;
        w_ok = 0;
        r = 2'h3;
        @(posedge aclk);
        p = rnd();
        s_axi_awaddr <= a;
        s_axi_awprot <= p[2:0];
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int t = 0; t <= 100; t++) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                break;
            end
            if (t == 100) chk("write answer", 32'h1, 32'h0);
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        logic [15:0] p;
        d = 32'hFFFFFFFF;
        r = 2'h3;
        @(posedge aclk);
        p = rnd();
        s_axi_araddr <= a;
        s_axi_arprot <= p[2:0];
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int t = 0; t <= 100; t++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                break;
            end
            if (t == 100) chk("read answer", 32'h1, 32'h0);
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic ctrl_wr(input logic [8:0] v);
        logic [1:0] r;
        axi_wr(CTRL_ADDR, 32'(v), 4'hF, r);
        chk("ctrl write resp", 32'(RESP_OKAY), 32'(r));
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(what, exp, d);
        chk("read resp", 32'(er), 32'(r));
    endtask

    task automatic do_reset(input logic hi, input logic lo);
        @(posedge aclk);
        aresetn <= 1'b0;
        dram_address_strap_high <= hi;
        dram_address_strap_low <= lo;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // Measures one whole high and low phase, starting from a rising edge
    task automatic clk_chk(input int half);
        int hi;
        int lo;
        hi = 0;
        lo = 0;
        for (int t = 0; t < 200 && serial_port_clock !== 1'b0; t++)
            @(posedge aclk);
        for (int t = 0; t < 200 && serial_port_clock !== 1'b1; t++)
            @(posedge aclk);
        while (serial_port_clock === 1'b1 && hi < 200) begin
            @(posedge aclk);
            hi++;
        end
        while (serial_port_clock === 1'b0 && lo < 200) begin
            @(posedge aclk);
            lo++;
        end
        chk("clock high cycles", 32'(half), 32'(hi));
        chk("clock low cycles", 32'(half), 32'(lo));
    endtask

    task automatic route_chk(input logic [1:0] c);
        logic [15:0] p;
        p = rnd();
        // Source on the idle pin clock, so status bits 1:0 read zero
        ctrl_wr({1'b1, 1'b0, c, 5'h03});
        pattern <= p[12:0];
        repeat (4) @(posedge aclk);
        chk("pin oe", 32'((c == 2'b00) ? OE_ALL_FIRST : OE_SHARED),
            32'(ext_pin_oe));
        chk("pin out", 32'(exp_out(c, p[12:0])), 32'(ext_pin_out));
        chk("core inputs", 32'(exp_core(c, p[12:0])), 32'({first_port_rxd,
            first_port_cts_n, first_port_dsr_n, first_port_dcd_n,
            first_port_ri_n, second_port_rxd, second_port_cts_n}));
        chk("enables", 32'({c == 2'b10, c != 2'b00, 1'b1}),
            32'({second_port_ir_mode, second_port_enable, first_port_enable}));
        rd_chk("status", STATUS_ADDR, 32'({c == 2'b10, c != 2'b00, 1'b1}) << 2,
               RESP_OKAY);
    endtask

    initial begin
        #3000000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        logic [1:0] r;
        logic [15:0] p;
        logic [4:0] divs [3];
        do_reset(1'b1, 1'b0);
        rd_chk("ctrl after reset", CTRL_ADDR, 32'h0000011B, RESP_OKAY);
        chk("first enable", 32'h1, 32'(first_port_enable));
        chk("second enable", 32'h0, 32'(second_port_enable));
        for (int k = 0; k < 8; k++) route_chk(k[1:0]);
        ctrl_wr(9'h0A3);
        repeat (2) @(posedge aclk);
        chk("first disabled", 32'h0, 32'(first_port_enable));
        // Lane one alone must move only the source select bit
        axi_wr(CTRL_ADDR, 32'h000001FF, 4'h2, r);
        rd_chk("ctrl strobe", CTRL_ADDR, 32'h000001A3, RESP_OKAY);
        axi_wr(8'h00, 32'h0, 4'hF, r);
        chk("unmapped write", 32'(RESP_SLVERR), 32'(r));
        rd_chk("unmapped read", 8'hFC, 32'h0, RESP_SLVERR);
        // Divisor kept non-zero: zero gives the same clock as divisor one
        p = rnd();
        divs = '{5'h01, 5'h1F, 5'(p[4:0] % 29 + 2)};
        foreach (divs[i]) begin
            ctrl_wr({4'h0, divs[i]});
            repeat (70) @(posedge aclk);
            clk_chk(int'(divs[i]));
        end
        clk_run <= 1'b1;
        ctrl_wr(9'h105);
        repeat (12) @(posedge aclk);
        clk_chk(3);
        clk_run <= 1'b0;
        do_reset(1'b0, 1'b1);
        rd_chk("ctrl reset two", CTRL_ADDR, 32'h0000007B, RESP_OKAY);
        chk("oe after reset", 32'(OE_SHARED), 32'(ext_pin_oe));
        report_and_stop();
    end
endmodule
